/* rtl/stt_top.sv */
// second-level trap/timer SMI status, speedup trigger and ACPI timer
// assumes: requests, events and enables are synchronous to CLK_SYS;
// TMR_TICK is a synchronous level at the timer base rate
//
// Contract
// - reading the mirror copy leaves every status bit unchanged
// - reading the clearing copy returns the bits then clears them all
// - clearing status drops the SMI; mirror reads keep it asserted
// - bit 5 set by enabled function one-four or legacy ISA trap
// - each function or ISA trap raises SMI only with its enable
// - bits 4,3,2 set by traps of user devices 3,2,1
// - user device trap raises SMI only with its enable bit
// - bit 1 set by timer 2 expiry, bit 0 by timer 1
// - timer expiry raises SMI only with its matching enable
// - any set status bit shows as the top-level traps/timers flag
// - speedup register read with speedup bit set invokes the handler
// - speedup read data is don't-care; no effect when modulation is off
// - read-only 24-bit ACPI counter increments on the timer base
// - upper eight bits of the timer register read zero
// - with its enable, an SMI fires each time the counter MSB toggles
// - timer SMI reported as the power management event
// - timer count also readable through a fixed I/O port
// - memory registers answer only with memory space enabled
// - registers decode in a 256-byte range; BAR low byte reads zero
`timescale 1ns/1ps
`include "stt_cfg.svh"
module stt_top (
  input wire logic CLK_SYS,              // core clock, 200 MHz
  input wire logic RST_N,                // asynchronous reset, active low
  input wire stt_pkg::stt_req_t REQ,     // memory, I/O and config access
  input wire stt_pkg::stt_evt_t EVT,     // trap and timer event pulses
  input wire stt_pkg::stt_en_t EN,       // enables held in function 0
  input wire logic TMR_TICK,             // timer base, about 14.3 MHz
  output logic [31:0] RD_DATA,           // read answer data
  output logic RD_VALID,                 // read answer strobe
  output logic SMI_REQ,                  // SMI from second-level status
  output logic TOP_GTT,                  // top-level traps/timers flag
  output logic PME_EVT,                  // ACPI timer SMI pulse
  output logic SPEEDUP_SMI               // speedup-disable SMI pulse
);
  import stt_pkg::*;

  stt_state_t q;
  stt_state_t d;
  logic [`STT_STS_W-1:0] set_v;
  logic hit;
  logic rd_mirror;
  logic rd_clear;
  logic rd_speedup;
  logic rd_timer;
  logic io_timer;
  logic tick_rise;
  logic [`STT_TMR_W-1:0] cnt_inc;
  logic msb_flip;
  logic [7:0] off;
  logic [`STT_BIT_USER_DEVICE_THREE_TRAP:0] lone_evt;
  logic [`STT_BIT_USER_DEVICE_THREE_TRAP:0] lone_en;
  wire [`STT_BIT_USER_DEVICE_THREE_TRAP:0] lone_set;

  assign off = REQ.addr[7:0];

  // user device and timer events map one to one onto status bits 4..0
  assign lone_evt = {EVT.udef, EVT.gpt};
  assign lone_en = {EN.udef, EN.gpt};
  for (genvar i = 0; i <= `STT_BIT_USER_DEVICE_THREE_TRAP; i++) begin : g_lone
    assign lone_set[i] = lone_evt[i] & lone_en[i];
  end

  always_comb begin
    d = q;
    // events are pulses; only enabled ones reach the status
    set_v = '0;
    set_v[`STT_BIT_FTRAP] = |(EVT.func_trap & EN.func_trap)
      | (EVT.isa_trap & EN.isa_trap);
    set_v[`STT_BIT_USER_DEVICE_THREE_TRAP:`STT_BIT_GPT1] = lone_set;

    // the whole 256-byte window decodes on BAR bits 31:8
    hit = REQ.mem_rd & q.mem_en & (REQ.addr[31:8] == q.bar);
    rd_mirror = hit & (off == `STT_OFF_MIRROR);
    rd_clear = hit & (off == `STT_OFF_CLEAR);
    rd_speedup = hit & (off == `STT_OFF_SPEEDUP);
    rd_timer = hit & (off == `STT_OFF_TIMER);
    io_timer = REQ.io_rd & (REQ.addr == `STT_IO_TIMER);

    // a set arriving with the clearing read survives it
    if (rd_clear) begin
      d.sts = set_v;
    end else begin
      d.sts = q.sts | set_v;
    end

    // timer base sampled as a level; count on its rising edge
    d.tick = TMR_TICK;
    tick_rise = TMR_TICK & ~q.tick;
    cnt_inc = q.cnt + 24'h000001;
    msb_flip = 1'h0;
    if (tick_rise) begin
      d.cnt = cnt_inc;
      msb_flip = cnt_inc[`STT_TMR_MSB] ^ q.cnt[`STT_TMR_MSB];
    end
    d.pme = msb_flip & EN.acpi_smi;

    // speedup read only matters while modulation is on
    d.spd = rd_speedup & EN.speedup_cfg & EN.susp_mod;

    // config side: command memory enable and BAR upper bits
    if (REQ.cfg_wr && REQ.addr[7:0] == `STT_CFG_CMD) begin
      d.mem_en = REQ.wdata[`STT_CMD_MEM_BIT];
    end
    if (REQ.cfg_wr && REQ.addr[7:0] == `STT_CFG_BAR) begin
      d.bar = REQ.wdata[31:8];
    end

    // unmapped offsets inside the window answer zero
    d.rd_valid = hit | io_timer | REQ.cfg_rd;
    d.rd_data = '0;
    if (rd_mirror || rd_clear) begin
      d.rd_data = {26'h0, q.sts};
    end else if (rd_timer || io_timer) begin
      d.rd_data = {8'h00, q.cnt};
    end else if (REQ.cfg_rd && REQ.addr[7:0] == `STT_CFG_CMD) begin
      d.rd_data = {30'h0, q.mem_en, 1'h0};
    end else if (REQ.cfg_rd && REQ.addr[7:0] == `STT_CFG_BAR) begin
      d.rd_data = {q.bar, 8'h00};
    end

    // SMI and top flag follow the status that will stand next cycle
    d.smi = |d.sts;
    d.gtt = |d.sts;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      q.sts <= `STT_STS_RST;
      q.bar <= `STT_BAR_RST;
      q.mem_en <= 1'h0;
      q.cnt <= `STT_TMR_RST;
      q.tick <= 1'h0;
      q.rd_data <= 32'h00000000;
      q.rd_valid <= 1'h0;
      q.smi <= 1'h0;
      q.gtt <= 1'h0;
      q.pme <= 1'h0;
      q.spd <= 1'h0;
    end else begin
      q <= d;
    end
  end

  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign SMI_REQ = q.smi;
  assign TOP_GTT = q.gtt;
  assign PME_EVT = q.pme;
  assign SPEEDUP_SMI = q.spd;

  // checks

  property p_mirror_keeps;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_mirror && set_v == '0) |=> (q.sts == $past(q.sts));
  endproperty
  a_mirror_keeps: assert property (p_mirror_keeps)
    else $error("mirror read changed status");

  property p_clear_reads;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_clear && set_v == '0) |=>
      (q.sts == '0) && q.rd_valid && (q.rd_data[5:0] == $past(q.sts));
  endproperty
  a_clear_reads: assert property (p_clear_reads)
    else $error("clearing read did not return and clear status");

  property p_smi_follows;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_clear && set_v == '0) |=> !SMI_REQ ##1 (SMI_REQ == (|q.sts));
  endproperty
  a_smi_follows: assert property (p_smi_follows)
    else $error("SMI not dropped by clearing read");

  property p_smi_kept;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (SMI_REQ && !rd_clear) |=> SMI_REQ;
  endproperty
  a_smi_kept: assert property (p_smi_kept)
    else $error("SMI dropped without clearing read");

  property p_ftrap_set;
    @(posedge CLK_SYS) disable iff (!RST_N)
    ((|(EVT.func_trap & EN.func_trap)) || (EVT.isa_trap && EN.isa_trap))
      |=> q.sts[`STT_BIT_FTRAP];
  endproperty
  a_ftrap_set: assert property (p_ftrap_set)
    else $error("function trap status not set");

  property p_ftrap_gated;
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(q.sts[`STT_BIT_FTRAP]) |->
      $past((|(EVT.func_trap & EN.func_trap)) || (EVT.isa_trap && EN.isa_trap));
  endproperty
  a_ftrap_gated: assert property (p_ftrap_gated)
    else $error("function trap status set without enabled event");

  property p_user_device_three_trap;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (EVT.udef[2] && EN.udef[2]) |=> q.sts[`STT_BIT_USER_DEVICE_THREE_TRAP] [*2] or
      (q.sts[`STT_BIT_USER_DEVICE_THREE_TRAP] ##1 $past(rd_clear));
  endproperty
  a_user_device_three_trap: assert property (p_user_device_three_trap)
    else $error("user device 3 status not set");

  property p_udef_gated;
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(q.sts[`STT_BIT_UDEF1]) |-> $past(EVT.udef[0] && EN.udef[0]);
  endproperty
  a_udef_gated: assert property (p_udef_gated)
    else $error("user device 1 status set while disabled");

  property p_gpt;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (EVT.gpt[1] && EN.gpt[1]) |=> q.sts[`STT_BIT_GPT2];
  endproperty
  a_gpt: assert property (p_gpt)
    else $error("timer 2 status not set");

  property p_gpt_gated;
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(q.sts[`STT_BIT_GPT1]) |-> $past(EVT.gpt[0] && EN.gpt[0]);
  endproperty
  a_gpt_gated: assert property (p_gpt_gated)
    else $error("timer 1 status set while disabled");

  property p_top_flag;
    @(posedge CLK_SYS) disable iff (!RST_N)
    TOP_GTT == (q.sts != '0);
  endproperty
  a_top_flag: assert property (p_top_flag)
    else $error("top-level flag disagrees with status");

  property p_speedup;
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_speedup |=> (SPEEDUP_SMI == $past(EN.speedup_cfg && EN.susp_mod));
  endproperty
  a_speedup: assert property (p_speedup)
    else $error("speedup read trigger wrong");

  property p_speedup_only;
    @(posedge CLK_SYS) disable iff (!RST_N)
    SPEEDUP_SMI |-> $past(rd_speedup && EN.susp_mod);
  endproperty
  a_speedup_only: assert property (p_speedup_only)
    else $error("speedup SMI without enabled read");

  property p_count;
    @(posedge CLK_SYS) disable iff (!RST_N)
    tick_rise |=> (q.cnt == $past(cnt_inc));
  endproperty
  a_count: assert property (p_count)
    else $error("timer did not advance on tick");

  property p_count_hold;
    @(posedge CLK_SYS) disable iff (!RST_N)
    !tick_rise |=> $stable(q.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("timer moved without tick");

  property p_timer_read;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_timer || io_timer) |=> RD_VALID && (RD_DATA[31:24] == 8'h00)
      && (RD_DATA[23:0] == $past(q.cnt));
  endproperty
  a_timer_read: assert property (p_timer_read)
    else $error("timer read data wrong");

  property p_msb_smi;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (tick_rise && EN.acpi_smi && (cnt_inc[`STT_TMR_MSB] != q.cnt[`STT_TMR_MSB]))
      |=> PME_EVT ##1 !PME_EVT;
  endproperty
  a_msb_smi: assert property (p_msb_smi)
    else $error("no timer SMI on MSB toggle");

  property p_pme_cause;
    @(posedge CLK_SYS) disable iff (!RST_N)
    PME_EVT |-> $past(EN.acpi_smi)
      && ($past(q.cnt[`STT_TMR_MSB]) != q.cnt[`STT_TMR_MSB]);
  endproperty
  a_pme_cause: assert property (p_pme_cause)
    else $error("timer SMI without MSB toggle");

  property p_io_timer;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.io_rd && REQ.addr == `STT_IO_TIMER) |=> RD_VALID;
  endproperty
  a_io_timer: assert property (p_io_timer)
    else $error("I/O timer read not answered");

  property p_mem_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.mem_rd && !q.mem_en && !REQ.io_rd && !REQ.cfg_rd) |=> !RD_VALID;
  endproperty
  a_mem_gate: assert property (p_mem_gate)
    else $error("memory read answered while disabled");

  property p_bar_low;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.cfg_rd && REQ.addr[7:0] == `STT_CFG_BAR) |=> (RD_DATA[7:0] == 8'h00);
  endproperty
  a_bar_low: assert property (p_bar_low)
    else $error("BAR low byte not zero");

  property p_sts_sticky;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (q.sts != '0 && !rd_clear) |=> ((q.sts & $past(q.sts)) == $past(q.sts));
  endproperty
  a_sts_sticky: assert property (p_sts_sticky)
    else $error("status bit lost without clearing read");

  property p_set_wins;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_clear && set_v != '0) |=> (q.sts == $past(set_v));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to a clearing read in the same cycle");

  property p_rsvd_zero;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (rd_mirror || rd_clear) |=> (RD_DATA[31:`STT_STS_W] == '0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bits not zero");

  property p_wrap;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (tick_rise && q.cnt == '1) |=> (q.cnt == '0);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer did not wrap to zero");

  property p_outside;
    @(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.mem_rd && REQ.addr[31:8] != q.bar && !REQ.io_rd && !REQ.cfg_rd) |=> !RD_VALID;
  endproperty
  a_outside: assert property (p_outside)
    else $error("memory read outside the window answered");

endmodule : stt_top

/* rtl/stt_cfg.svh */
// offsets, field positions and reset values of the trap/timer status block
// assumes: included by the package and the top module by bare name
`ifndef STT_CFG_SVH
`define STT_CFG_SVH
`define STT_OFF_MIRROR 8'h04
`define STT_OFF_CLEAR 8'h06
`define STT_OFF_SPEEDUP 8'h08
`define STT_OFF_TIMER 8'h1C
`define STT_CFG_CMD 8'h04
`define STT_CFG_BAR 8'h10
`define STT_CMD_MEM_BIT 1
`define STT_IO_TIMER 32'h0000121C
`define STT_STS_W 6
`define STT_BIT_FTRAP 5
`define STT_BIT_USER_DEVICE_THREE_TRAP 4
`define STT_BIT_UDEF2 3
`define STT_BIT_UDEF1 2
`define STT_BIT_GPT2 1
`define STT_BIT_GPT1 0
`define STT_TMR_W 24
`define STT_TMR_MSB 23
`define STT_TMR_RST 24'hFFFFFC
`define STT_STS_RST 6'h00
`define STT_BAR_RST 24'h000000
`endif

/* rtl/stt_pkg.sv */
// types shared by the trap/timer status block and its surroundings
// assumes: constants come from stt_cfg.svh
`include "stt_cfg.svh"
package stt_pkg;
  typedef struct packed {
    logic mem_rd;
    logic io_rd;
    logic cfg_rd;
    logic cfg_wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } stt_req_t;
  typedef struct packed {
    logic [3:0] func_trap;
    logic isa_trap;
    logic [2:0] udef;
    logic [1:0] gpt;
  } stt_evt_t;
  typedef struct packed {
    logic [3:0] func_trap;
    logic isa_trap;
    logic [2:0] udef;
    logic [1:0] gpt;
    logic acpi_smi;
    logic speedup_cfg;
    logic susp_mod;
  } stt_en_t;
  typedef struct packed {
    logic [`STT_STS_W-1:0] sts;
    logic [23:0] bar;
    logic mem_en;
    logic [`STT_TMR_W-1:0] cnt;
    logic tick;
    logic [31:0] rd_data;
    logic rd_valid;
    logic smi;
    logic gtt;
    logic pme;
    logic spd;
  } stt_state_t;
endpackage : stt_pkg

/* test/stt_host.sv */
// host model: issues config, memory and I/O reads to the status block
// assumes: answers come one cycle after a request, as the block promises
`timescale 1ns/1ps
module stt_host (
  input wire logic CLK_SYS, // core clock
  input wire logic [31:0] RD_DATA, // read answer
  input wire logic RD_VALID, // answer strobe
  output stt_pkg::stt_req_t REQ // request to the block
);
  import stt_pkg::*;
  initial REQ = '0;
  // kind is {mem_rd, io_rd, cfg_rd, cfg_wr}; one-cycle pulse, answer sampled one cycle later at the negedge that drops it
  task automatic xfer(input logic [3:0] kind, input logic [31:0] addr,
      input logic [31:0] wdata, output logic [31:0] data, output logic valid);
    @(negedge CLK_SYS);
    {REQ.mem_rd, REQ.io_rd, REQ.cfg_rd, REQ.cfg_wr} = kind;
    REQ.addr = addr;
    REQ.wdata = wdata;
    @(negedge CLK_SYS);
    valid = RD_VALID;
    data = RD_DATA;
    {REQ.mem_rd, REQ.io_rd, REQ.cfg_rd, REQ.cfg_wr} = 4'h0;
    // released lines carry the inverse so a stale value never looks live
    REQ.addr = ~addr;
    REQ.wdata = ~wdata;
  endtask : xfer
endmodule : stt_host

/* test/tb.sv */
// self-checking bench for the trap/timer status block
// assumes: stt_host drives the request port; integer model predicts results
`timescale 1ns/1ps
`include "stt_cfg.svh"
module tb;
  import stt_pkg::*;
  logic clk_sys;
  logic rst_n;
  stt_req_t req;
  stt_evt_t evt;
  stt_en_t en;
  logic tmr_tick;
  logic [31:0] rd_data;
  logic rd_valid, smi_req, top_gtt, pme_evt, speedup_smi;
  logic [31:0] d, bar;
  logic v;
  int n_fail = 0, n_checks = 0, cycles = 0, n_pme = 0, seed, m_sts, m_cnt;
  stt_top u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ(req), .EVT(evt), .EN(en),
    .TMR_TICK(tmr_tick), .RD_DATA(rd_data), .RD_VALID(rd_valid), .SMI_REQ(smi_req),
    .TOP_GTT(top_gtt), .PME_EVT(pme_evt), .SPEEDUP_SMI(speedup_smi));
  stt_host u_host (.CLK_SYS(clk_sys), .RD_DATA(rd_data), .RD_VALID(rd_valid), .REQ(req));
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (pme_evt === 1'h1) n_pme++;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic mrd(input logic [7:0] off);
    u_host.xfer(4'h8, bar | off, 32'h0, d, v);
  endtask : mrd
  task automatic setup;
    u_host.xfer(4'h1, `STT_CFG_BAR, bar | 32'hFF, d, v);
    u_host.xfer(4'h1, `STT_CFG_CMD, 32'h2, d, v);
  endtask : setup
  // event layout: func_trap 9..6, isa 5, udef 4..2, gpt 1..0; enables sit 3 bits higher
  task automatic pulse(input int b);
    @(negedge clk_sys);
    evt = stt_evt_t'(10'h001 << b);
    @(negedge clk_sys);
    evt = '0;
    if (en[b+3]) m_sts |= 1 << ((b >= 5) ? 5 : b);
    check("smi", smi_req, m_sts != 0);
    check("gtt", top_gtt, m_sts != 0);
  endtask : pulse
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_sys) tmr_tick = 1;
      @(negedge clk_sys) tmr_tick = 0;
      m_cnt = (m_cnt + 1) & 32'hFFFFFF;
    end
  endtask : tick
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    seed = 32'he1fa399e;
    rst_n = 0;
    evt = '0;
    en = '0;
    tmr_tick = 0;
    m_sts = 0;
    m_cnt = 32'hFFFFFC;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst_n = 1;
    bar = $random(seed) & 32'hFFFFFF00;
    mrd(`STT_OFF_TIMER);
    check("refused", v, 0);
    setup();
    u_host.xfer(4'h2, `STT_CFG_BAR, 32'h0, d, v);
    check("bar", d, bar);
    mrd(`STT_OFF_TIMER);
    check("timer_rst", d, m_cnt);
    mrd(`STT_OFF_CLEAR);
    check("sts_rst", d, 0);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      en = stt_en_t'({10'($random(seed)), 3'h0});
      for (int b = 0; b < 10; b++) pulse(b);
      mrd(`STT_OFF_MIRROR);
      check("mirror", d, m_sts);
      mrd(`STT_OFF_MIRROR);
      check("mirror2", d, m_sts);
      check("smi_kept", smi_req, m_sts != 0);
      mrd(`STT_OFF_CLEAR);
      check("clear", d, m_sts);
      m_sts = 0;
      mrd(`STT_OFF_MIRROR);
      check("cleared", d, 0);
      check("smi_drop", smi_req, 0);
    end
    // event in the very cycle of a clearing read must survive it
    en.gpt = 2'h3;
    fork
      mrd(`STT_OFF_CLEAR);
      begin
        @(negedge clk_sys);
        evt.gpt = 2'h1;
        @(negedge clk_sys);
        evt = '0;
      end
    join
    check("clear_same", d, m_sts);
    m_sts = 1 << `STT_BIT_GPT1;
    mrd(`STT_OFF_MIRROR);
    check("set_wins", d, m_sts);
    check("smi_set", smi_req, 1);
    mrd(`STT_OFF_CLEAR);
    check("clear_late", d, m_sts);
    m_sts = 0;
    $display("test status done");
    u_host.xfer(4'h8, bar ^ 32'h100, 32'h0, d, v);
    check("outside", v, 0);
    mrd(8'h0C);
    check("unmapped", d, 0);
    u_host.xfer(4'h4, `STT_IO_TIMER, 32'h0, d, v);
    check("io_timer", d, m_cnt);
    u_host.xfer(4'h4, `STT_IO_TIMER + 32'h4, 32'h0, d, v);
    check("io_other", v, 0);
    $display("test decode done");
    for (int k = 0; k < 4; k++) begin
      en.speedup_cfg = k[0];
      en.susp_mod = k[1];
      mrd(`STT_OFF_SPEEDUP);
      check("speedup", speedup_smi, k == 3);
    end
    $display("test speedup done");
    en.acpi_smi = 1;
    tick(3);
    check("pme_early", n_pme, 0);
    tick(1 + ($unsigned($random(seed)) % 8));
    mrd(`STT_OFF_TIMER);
    check("timer_wrap", d, m_cnt);
    check("pme", n_pme, 1);
    @(negedge clk_sys) rst_n = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    m_cnt = 32'hFFFFFC;
    en.acpi_smi = 0;
    n_pme = 0;
    setup();
    tick(5);
    mrd(`STT_OFF_TIMER);
    check("timer_rerst", d, m_cnt);
    check("pme_off", n_pme, 0);
    check("smi_rst", smi_req, 0);
    $display("test timer done");
    finish_test();
  end
endmodule : tb
